//--- core/swm_cfg.svh
// register offsets, field positions, reset values and limits
`ifndef SWM_CFG_SVH
`define SWM_CFG_SVH
`define SWM_A_CTRL 8'h00
`define SWM_A_IN_MAP 8'h04
`define SWM_A_OUT_MAP 8'h08
`define SWM_A_MOT_PWR 8'h0C
`define SWM_A_DRV_PWR 8'h10
`define SWM_A_MAX_SPD 8'h14
`define SWM_A_STATUS 8'h18
`define SWM_A_ACT_IN 8'h1C
`define SWM_A_ACT_OUT 8'h20
`define SWM_A_CMD 8'h24
`define SWM_B_CLS_Q 0
`define SWM_B_SERIAL 1
`define SWM_B_RES17 2
`define SWM_B_STAT_DISP 3
`define SWM_F_MODE 4
`define SWM_R_CTRL 32'h0000_000B
`define SWM_R_MAP 32'h0000_0000
`define SWM_R_MOT_PWR 32'h0000_0190
`define SWM_R_DRV_PWR 32'h0000_0190
`define SWM_R_MAX_SPD 32'h0000_0BB8
// 3.2 V in millivolts
`define SWM_BATT_MV 16'h0C80
`define SWM_REV_LIM_Q 33'h0000_8000
`define SWM_REV_LIM_H 33'h0000_1000
// rpm
`define SWM_INIT_RPM 17'h0064
// percent of rated torque
`define SWM_TRQ_LIM 17'h012C
`define SWM_FLICK_MS 32'h0000_00FA
`define SWM_CLK_MHZ 32'h0000_00C8
`define SWM_FLICK_CYC (`SWM_FLICK_MS * `SWM_CLK_MHZ * 32'h0000_03E8)
`endif

//--- core/swm_pkg.sv
// types shared by the warning monitor
package swm_pkg;
  typedef enum logic [2:0] {
    SWM_PWR_OFF = 3'b001,
    SWM_PWR_LOAD = 3'b010,
    SWM_PWR_ON = 3'b100
  } swm_pwr_t;
  typedef enum logic [1:0] {
    SWM_MODE_SINGLE = 2'h0,
    SWM_MODE_MIXED = 2'h1,
    SWM_MODE_MULTI = 2'h2
  } swm_mode_t;
endpackage

//--- core/swm_axil.sv
// axi4-lite slave front end for the register file
`timescale 1ns/1ps
`default_nettype none
module swm_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic reg_wr,
  output logic [7:0] reg_waddr,
  output logic [31:0] reg_wdata,
  output logic [3:0] reg_wstrb,
  input wire logic reg_whit,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rhit
);
  logic aw_held;
  logic w_held;
  assign s_awready = !aw_held && !s_bvalid;
  assign s_wready = !w_held && !s_bvalid;
  assign s_arready = !s_rvalid;
  assign reg_wr = aw_held && w_held && !s_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      reg_waddr <= 8'h00;
      reg_wdata <= 32'h0000_0000;
      reg_wstrb <= 4'h0;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_held <= 1'b1;
        reg_waddr <= s_awaddr;
      end
      else if (reg_wr)
        aw_held <= 1'b0;
      if (s_wvalid && s_wready)
      begin
        w_held <= 1'b1;
        reg_wdata <= s_wdata;
        reg_wstrb <= s_wstrb;
      end
      else if (reg_wr)
        w_held <= 1'b0;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
    end
    else if (reg_wr)
    begin
      s_bvalid <= 1'b1;
      s_bresp <= reg_whit ? 2'h0 : 2'h2;
    end
    else if (s_bready)
      s_bvalid <= 1'b0;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= 2'h0;
    end
    else if (s_arvalid && s_arready)
    begin
      s_rvalid <= 1'b1;
      s_rdata <= reg_rhit ? reg_rdata : 32'h0000_0000;
      s_rresp <= reg_rhit ? 2'h0 : 2'h2;
    end
    else if (s_rready)
      s_rvalid <= 1'b0;
  end
endmodule // swm_axil
`default_nettype wire

//--- core/swm_disp.sv
// three-digit seven-segment warning character with flicker
`timescale 1ns/1ps
`default_nettype none
module swm_disp #(
  parameter int FLICK_CYC = 50000000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic [2:0] warn_id,
  output logic [20:0] seg
);
  logic [31:0] cnt;
  logic phase;
  logic [20:0] glyph;
  // glyph per character: digit2, digit1, digit0
  always_comb
  begin
    case (warn_id)
      3'h0: glyph = {7'h73, 7'h38, 7'h40};
      3'h1: glyph = {7'h7C, 7'h77, 7'h78};
      3'h2: glyph = {7'h6D, 7'h54, 7'h78};
      3'h3: glyph = {7'h06, 7'h54, 7'h06};
      3'h4: glyph = {7'h3F, 7'h78, 7'h50};
      3'h5: glyph = {7'h3F, 7'h6D, 7'h73};
      3'h6: glyph = {7'h06, 7'h3F, 7'h77};
      3'h7: glyph = {7'h3F, 7'h39, 7'h77};
      default: glyph = 21'h00_0000;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || warn_id == 3'h0)
    begin
      cnt <= 32'h0000_0000;
      phase <= 1'b1;
    end
    else if (cnt >= 32'(FLICK_CYC - 1))
    begin
      cnt <= 32'h0000_0000;
      phase <= !phase;
    end
    else
      cnt <= cnt + 32'h0000_0001;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      seg <= 21'h00_0000;
    else if (enable && phase)
      seg <= glyph;
    else
      seg <= 21'h00_0000;
  end
endmodule // swm_disp
`default_nettype wire

//--- core/swm_monitor.sv
// servo warning monitor top: inputs, flags, clamps, registers
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "swm_cfg.svh"
module swm_monitor #(
  parameter int FLICK_CYC = `SWM_FLICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic main_power,
  input wire logic [15:0] battery_mv,
  input wire logic [31:0] rev_count,
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] torque_cmd,
  input wire logic [15:0] speed_cmd,
  output logic [15:0] torque_lim,
  output logic [15:0] speed_lim,
  output logic run_permit,
  output logic [6:0] warn_flags,
  output logic warn_out,
  output logic [20:0] seg
);
  logic reg_wr;
  logic [7:0] reg_waddr;
  logic [31:0] reg_wdata;
  logic [3:0] reg_wstrb;
  logic reg_whit;
  logic [31:0] reg_rdata;
  logic reg_rhit;
  logic [31:0] ctrl;
  logic [31:0] in_map;
  logic [31:0] out_map;
  logic [31:0] act_in;
  logic [31:0] act_out;
  logic [31:0] mot_pwr;
  logic [31:0] drv_pwr;
  logic [31:0] max_spd;
  logic pwr_s1;
  logic pwr_s2;
  logic pwr_s3;
  logic pwr_lvl;
  swm_pkg::swm_pwr_t pwr_state;
  swm_pkg::swm_pwr_t next_pwr_state;
  swm_pkg::swm_mode_t mode;
  logic init_flag;
  logic [6:0] next_warn;
  logic [2:0] warn_id;
  logic [16:0] trq_mag;
  logic [16:0] spd_mag;
  logic [16:0] mot_mag;
  logic [32:0] rev_mag;
  logic [32:0] rev_lim;

  // merge a written word into a register by byte strobes
  function automatic logic [31:0] swm_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    return r;
  endfunction

  // two assigned signals on one channel; channel 0 means unassigned
  function automatic logic swm_dup(input logic [31:0] m);
    logic d;
    d = 1'b0;
    for (int i = 0; i < 8; i++)
      for (int j = i + 1; j < 8; j++)
        if (m[4*i +: 4] != 4'h0 && m[4*i +: 4] == m[4*j +: 4])
          d = 1'b1;
    return d;
  endfunction

  // magnitude of a signed 16-bit value, wide enough for -32768
  function automatic logic [16:0] swm_mag16(input logic [15:0] v);
    logic [16:0] e;
    e = {v[15], v};
    return v[15] ? 17'(-e) : e;
  endfunction

  swm_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .reg_wr(reg_wr),
    .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata),
    .reg_wstrb(reg_wstrb),
    .reg_whit(reg_whit),
    .reg_rdata(reg_rdata),
    .reg_rhit(reg_rhit)
  );

  // writable registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= `SWM_R_CTRL;
      in_map <= `SWM_R_MAP;
      out_map <= `SWM_R_MAP;
      mot_pwr <= `SWM_R_MOT_PWR;
      drv_pwr <= `SWM_R_DRV_PWR;
      max_spd <= `SWM_R_MAX_SPD;
    end
    else if (reg_wr)
    begin
      case (reg_waddr)
        `SWM_A_CTRL: ctrl <= swm_merge(ctrl, reg_wdata, reg_wstrb);
        `SWM_A_IN_MAP: in_map <= swm_merge(in_map, reg_wdata, reg_wstrb);
        `SWM_A_OUT_MAP: out_map <= swm_merge(out_map, reg_wdata, reg_wstrb);
        `SWM_A_MOT_PWR: mot_pwr <= swm_merge(mot_pwr, reg_wdata, reg_wstrb);
        `SWM_A_DRV_PWR: drv_pwr <= swm_merge(drv_pwr, reg_wdata, reg_wstrb);
        `SWM_A_MAX_SPD: max_spd <= swm_merge(max_spd, reg_wdata, reg_wstrb);
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (reg_waddr)
      `SWM_A_CTRL, `SWM_A_IN_MAP, `SWM_A_OUT_MAP, `SWM_A_MOT_PWR,
      `SWM_A_DRV_PWR, `SWM_A_MAX_SPD: reg_whit = 1'b1;
      default: reg_whit = 1'b0;
    endcase
  end

  // read decode, address taken straight from the read channel
  always_comb
  begin
    reg_rhit = 1'b1;
    case (s_araddr)
      `SWM_A_CTRL: reg_rdata = ctrl;
      `SWM_A_IN_MAP: reg_rdata = in_map;
      `SWM_A_OUT_MAP: reg_rdata = out_map;
      `SWM_A_MOT_PWR: reg_rdata = mot_pwr;
      `SWM_A_DRV_PWR: reg_rdata = drv_pwr;
      `SWM_A_MAX_SPD: reg_rdata = max_spd;
      `SWM_A_STATUS: reg_rdata = {19'h0_0000, pwr_lvl, warn_out,
                                  warn_id, 1'b0, warn_flags};
      `SWM_A_ACT_IN: reg_rdata = act_in;
      `SWM_A_ACT_OUT: reg_rdata = act_out;
      `SWM_A_CMD: reg_rdata = {speed_lim, torque_lim};
      default:
      begin
        reg_rdata = 32'h0000_0000;
        reg_rhit = 1'b0;
      end
    endcase
  end

  assign mode = swm_pkg::swm_mode_t'(ctrl[`SWM_F_MODE +: 2]);

  // main power pin: three-stage synchroniser, level moves on agreement
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwr_s1 <= 1'b0;
      pwr_s2 <= 1'b0;
      pwr_s3 <= 1'b0;
      pwr_lvl <= 1'b0;
    end
    else
    begin
      pwr_s1 <= main_power;
      pwr_s2 <= pwr_s1;
      pwr_s3 <= pwr_s2;
      if (pwr_s2 == pwr_s3)
        pwr_lvl <= pwr_s3;
    end
  end

  always_comb
  begin
    case (pwr_state)
      swm_pkg::SWM_PWR_OFF:
        next_pwr_state = pwr_lvl ? swm_pkg::SWM_PWR_LOAD
                                 : swm_pkg::SWM_PWR_OFF;
      swm_pkg::SWM_PWR_LOAD: next_pwr_state = swm_pkg::SWM_PWR_ON;
      swm_pkg::SWM_PWR_ON:
        next_pwr_state = pwr_lvl ? swm_pkg::SWM_PWR_ON
                                 : swm_pkg::SWM_PWR_OFF;
      default: next_pwr_state = swm_pkg::SWM_PWR_OFF;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pwr_state <= swm_pkg::SWM_PWR_OFF;
    else
      pwr_state <= next_pwr_state;
  end

  // channel assignment copied only on the power-up step
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      act_in <= `SWM_R_MAP;
      act_out <= `SWM_R_MAP;
    end
    else if (pwr_state == swm_pkg::SWM_PWR_LOAD)
    begin
      act_in <= in_map;
      act_out <= out_map;
    end
  end

  assign mot_mag = swm_mag16(motor_speed);
  assign trq_mag = swm_mag16(torque_cmd);
  assign spd_mag = swm_mag16(speed_cmd);
  assign rev_mag = rev_count[31] ? 33'(-{1'b1, rev_count})
                                 : {1'b0, rev_count};
  assign rev_lim = ctrl[`SWM_B_CLS_Q] ? `SWM_REV_LIM_Q : `SWM_REV_LIM_H;

  // speed sampled at the power-on step; cleared for 17-bit resolution or with the serial bit clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      init_flag <= 1'b0;
    else if (!ctrl[`SWM_B_SERIAL] || ctrl[`SWM_B_RES17])
      init_flag <= 1'b0;
    else if (pwr_state == swm_pkg::SWM_PWR_LOAD)
      init_flag <= mot_mag > `SWM_INIT_RPM;
  end

  always_comb
  begin
    next_warn[0] = battery_mv <= `SWM_BATT_MV;
    next_warn[1] = rev_mag > rev_lim;
    next_warn[2] = init_flag;
    next_warn[3] = trq_mag >= `SWM_TRQ_LIM;
    next_warn[4] = spd_mag >= {1'b0, max_spd[15:0]};
    next_warn[5] = swm_dup(act_in) || swm_dup(act_out);
    if (mode == swm_pkg::SWM_MODE_MIXED && act_in[3:0] == 4'h0)
      next_warn[5] = 1'b1;
    if (mode == swm_pkg::SWM_MODE_MULTI && (act_in[7:4] == 4'h0 ||
        act_in[11:8] == 4'h0 || act_in[15:12] == 4'h0))
      next_warn[5] = 1'b1;
    next_warn[6] = mot_pwr > drv_pwr;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      warn_flags <= 7'h00;
    else
      warn_flags <= next_warn;
  end

  always_comb
  begin
    warn_id = 3'h0;
    for (int i = 6; i >= 0; i--)
      if (warn_flags[i])
        warn_id = 3'(i + 1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      warn_out <= 1'b0;
    else
      warn_out <= (|next_warn) && act_out[3:0] != 4'h0;
  end

  // commands are clamped, never blocked
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      torque_lim <= 16'h0000;
      speed_lim <= 16'h0000;
    end
    else
    begin
      if (trq_mag >= `SWM_TRQ_LIM)
        torque_lim <= torque_cmd[15] ? 16'(-`SWM_TRQ_LIM)
                                     : 16'(`SWM_TRQ_LIM);
      else
        torque_lim <= torque_cmd;
      if (spd_mag >= {1'b0, max_spd[15:0]})
        speed_lim <= speed_cmd[15] ? 16'(-max_spd[15:0])
                                   : max_spd[15:0];
      else
        speed_lim <= speed_cmd;
    end
  end

  assign run_permit = 1'b1;

  swm_disp #(
    .FLICK_CYC(FLICK_CYC)
  ) u_disp (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(ctrl[`SWM_B_STAT_DISP]),
    .warn_id(warn_id),
    .seg(seg)
  );
endmodule // swm_monitor
`default_nettype wire

//--- testbench/swm_monitor_asserts.sv
// port checker for the servo warning monitor
`timescale 1ns/1ps
`default_nettype none
module swm_monitor_asserts #(
  parameter int FLICK_CYC = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [15:0] battery_mv,
  input wire logic [15:0] torque_cmd,
  input wire logic [15:0] torque_lim,
  input wire logic run_permit,
  input wire logic [6:0] warn_flags,
  input wire logic warn_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  function automatic logic [15:0] clamp(logic [15:0] t);
    if ($signed(t) >= 300)
      return 16'h012C;
    if ($signed(t) <= -300)
      return 16'hFED4;
    return t;
  endfunction
  function automatic logic over(logic [15:0] t);
    return ($signed(t) >= 300) || ($signed(t) <= -300);
  endfunction
  sequence s_wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence s_rd_taken;
    s_arvalid && s_arready;
  endsequence
  property p_batt;
    $past(aresetn) |-> warn_flags[0] == ($past(battery_mv) <= 16'h0C80);
  endproperty
  property p_trq_flag;
    $past(aresetn) |-> warn_flags[3] == over($past(torque_cmd));
  endproperty
  property p_trq_lim;
    $past(aresetn) |-> torque_lim == clamp($past(torque_cmd));
  endproperty
  property p_permit;
    run_permit;
  endproperty
  property p_out_or;
    warn_out |-> warn_flags != 7'h00;
  endproperty
  property p_bhold;
    s_bvalid && !s_bready |=> s_bvalid;
  endproperty
  property p_rhold;
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
  endproperty
  property p_wr_resp;
    s_wr_taken |-> ##[1:2] s_bvalid;
  endproperty
  property p_rd_resp;
    s_rd_taken |=> s_rvalid;
  endproperty
  a_batt: assert property (p_batt)
    else $error("battery flag mismatch");
  a_trq_flag: assert property (p_trq_flag)
    else $error("torque flag mismatch");
  a_trq_lim: assert property (p_trq_lim)
    else $error("torque clamp mismatch");
  a_permit: assert property (p_permit)
    else $error("operation stopped");
  a_out_or: assert property (p_out_or)
    else $error("warning output without flag");
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
  a_rhold: assert property (p_rhold)
    else $error("read data dropped");
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response late");
  a_rd_resp: assert property (p_rd_resp)
    else $error("read response late");
endmodule // swm_monitor_asserts
bind swm_monitor swm_monitor_asserts #(.FLICK_CYC(FLICK_CYC)) u_chk (
  .aclk, .aresetn, .s_awvalid, .s_awready, .s_wvalid, .s_wready,
  .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rdata, .s_rvalid,
  .s_rready, .battery_mv, .torque_cmd, .torque_lim, .run_permit,
  .warn_flags, .warn_out);
`default_nettype wire

//--- testbench/swm_host.sv
// host controller model watching the warning output line
`timescale 1ns/1ps
`default_nettype none
module swm_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic warn_out,
  output logic seen,
  output logic [7:0] n_rise
);
  // latches the level each cycle and counts new warnings
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seen <= 1'b0;
      n_rise <= 8'h00;
    end
    else
    begin
      seen <= warn_out;
      if (warn_out && !seen)
        n_rise <= n_rise + 8'h01;
    end
  end
endmodule // swm_host
`default_nettype wire

//--- testbench/swm_monitor_tb.sv
// self-checking testbench for the servo warning monitor
`timescale 1ns/1ps
`default_nettype none
module swm_monitor_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00;
  logic [7:0] s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awvalid = 1'b0;
  logic s_wvalid = 1'b0;
  logic s_bready = 1'b0;
  logic s_arvalid = 1'b0;
  logic s_rready = 1'b0;
  logic main_power = 1'b0;
  logic [15:0] battery_mv = 16'h0E10;
  logic [31:0] rev_count = 32'h0;
  logic [15:0] motor_speed = 16'h0;
  logic [15:0] torque_cmd = 16'h0;
  logic [15:0] speed_cmd = 16'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, rs;
  logic [31:0] s_rdata, rd;
  logic [15:0] torque_lim, speed_lim;
  logic run_permit, warn_out, seen;
  logic [6:0] warn_flags;
  logic [20:0] seg, g1, g2;
  logic [7:0] n_rise;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int ch;
  always #2.5 aclk = ~aclk;
  swm_monitor #(.FLICK_CYC(8)) DUT (.aclk, .aresetn, .s_awaddr,
    .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .main_power, .battery_mv,
    .rev_count, .motor_speed, .torque_cmd, .speed_cmd, .torque_lim,
    .speed_lim, .run_permit, .warn_flags, .warn_out, .seg);
  swm_host u_host (.aclk, .aresetn, .warn_out, .seen, .n_rise);
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic pa, pw, ta, tw, b;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw)
    begin
      @(negedge aclk);
      ta = pa && s_awready;
      tw = pw && s_wready;
      @(posedge aclk);
      if (ta)
        s_awvalid <= 1'b0;
      if (tw)
        s_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do
    begin
      @(negedge aclk);
      b = s_bvalid;
      rs = s_bresp;
      @(posedge aclk);
    end while (!b);
    s_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, rs});
  endtask
  task automatic rdr(input logic [7:0] a);
    logic t;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      t = s_arready;
      @(posedge aclk);
    end while (!t);
    s_arvalid <= 1'b0;
    do
    begin
      @(negedge aclk);
      t = s_rvalid;
      rd = s_rdata;
      rs = s_rresp;
      @(posedge aclk);
    end while (!t);
    s_rready <= 1'b0;
  endtask
  task automatic fl(input logic [6:0] ef);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk("flags", {25'h0, ef}, {25'h0, warn_flags});
  endtask
  function automatic logic [15:0] clampv(logic [15:0] v, int m);
    if ($signed(v) >= m)
      return m[15:0];
    if ($signed(v) <= -m)
      return -m[15:0];
    return v;
  endfunction
  task automatic probe(input logic [15:0] b, t, s,
    input logic [31:0] r, input logic [6:0] ef);
    @(posedge aclk);
    battery_mv <= b;
    torque_cmd <= t;
    speed_cmd <= s;
    rev_count <= r;
    fl(ef);
    chk("torque_lim", {16'h0, clampv(t, 300)}, {16'h0, torque_lim});
    chk("speed_lim", {16'h0, clampv(s, 3000)}, {16'h0, speed_lim});
  endtask
  task automatic pwr();
    @(posedge aclk);
    main_power <= 1'b0;
    repeat (8) @(posedge aclk);
    main_power <= 1'b1;
    repeat (12) @(posedge aclk);
  endtask
  task automatic segw(output int n, output logic [20:0] g);
    logic [20:0] p;
    n = 0;
    g = 21'h0;
    @(negedge aclk);
    p = seg;
    repeat (24)
    begin
      @(negedge aclk);
      if (seg !== p)
        n++;
      if (seg !== 21'h0)
        g = seg;
      p = seg;
    end
  endtask
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(8'h00);
    chk("ctrl", 32'h0000000B, rd);
    rdr(8'h14);
    chk("max_spd", 32'h00000BB8, rd);
    rdr(8'h40);
    chk("unmapped", 32'h2, {30'h0, rs});
    wr(8'h18, 32'h1, 2'h2);
    chk("permit", 32'h1, {31'h0, run_permit});
    probe(16'h0E10, 16'h0, 16'h0, 32'h0, 7'h00);
    probe(16'h0C80, 16'h0, 16'h0, 32'h0, 7'h01);
    probe(16'h0C81, 16'h0, 16'h0, 32'h0, 7'h00);
    probe(16'h0E10, 16'h0, 16'h0, 32'h8000, 7'h00);
    probe(16'h0E10, 16'h0, 16'h0, 32'h8001, 7'h02);
    probe(16'h0E10, 16'h0, 16'h0, 32'hFFFF7FFF, 7'h02);
    probe(16'h0E10, 16'h012B, 16'h0, 32'h0, 7'h00);
    probe(16'h0E10, 16'h012C, 16'h0, 32'h0, 7'h08);
    probe(16'h0E10, 16'hFE70, 16'h0, 32'h0, 7'h08);
    probe(16'h0E10, 16'h0, 16'h0BB7, 32'h0, 7'h00);
    probe(16'h0E10, 16'h0, 16'h0FA0, 32'h0, 7'h10);
    probe(16'h0E10, 16'h0, 16'h0BB8, 32'h0, 7'h10);
    wr(8'h00, 32'h0000000A, 2'h0);
    probe(16'h0E10, 16'h0, 16'h0, 32'h1001, 7'h02);
    probe(16'h0E10, 16'h0, 16'h0, 32'hFFFFF000, 7'h00);
    wr(8'h00, 32'h0000000B, 2'h0);
    probe(16'h0C80, 16'h0, 16'h0, 32'h0, 7'h01);
    segw(ch, g1);
    chk("flicker", 32'h1, {31'h0, ch != 0});
    probe(16'h0C80, 16'h012C, 16'h0, 32'h0, 7'h09);
    rdr(8'h18);
    chk("warn_id", 32'h1, {29'h0, rd[10:8]});
    chk("warn_out", 32'h0, {31'h0, warn_out});
    wr(8'h08, 32'h00000001, 2'h0);
    fl(7'h09);
    chk("warn_out", 32'h0, {31'h0, warn_out});
    pwr();
    fl(7'h09);
    chk("warn_out", 32'h1, {31'h0, warn_out});
    chk("host", 32'h1, {31'h0, seen});
    rdr(8'h20);
    chk("act_out", 32'h1, rd);
    probe(16'h0E10, 16'h012C, 16'h0, 32'h0, 7'h08);
    rdr(8'h24);
    chk("cmd", 32'h0000012C, rd);
    segw(ch, g2);
    chk("glyph", 32'h1, {31'h0, g1 !== g2});
    probe(16'h0E10, 16'h0, 16'h0, 32'h0, 7'h00);
    chk("warn_out", 32'h0, {31'h0, warn_out});
    segw(ch, g2);
    chk("steady", 32'h0, ch);
    chk("shown", 32'h1, {31'h0, seg !== 21'h0});
    wr(8'h00, 32'h00000003, 2'h0);
    fl(7'h00);
    chk("blank", 32'h0, {11'h0, seg});
    wr(8'h04, 32'h00000011, 2'h0);
    fl(7'h00);
    pwr();
    fl(7'h20);
    wr(8'h04, 32'h0, 2'h0);
    wr(8'h00, 32'h0000001B, 2'h0);
    pwr();
    fl(7'h20);
    wr(8'h00, 32'h0000002B, 2'h0);
    pwr();
    fl(7'h20);
    wr(8'h04, 32'h00004320, 2'h0);
    pwr();
    fl(7'h00);
    rdr(8'h1C);
    chk("act_in", 32'h00004320, rd);
    @(posedge aclk);
    s_wstrb <= 4'h1;
    wr(8'h0C, 32'hFFFFFF91, 2'h0);
    s_wstrb <= 4'hF;
    fl(7'h40);
    wr(8'h10, 32'h00000191, 2'h0);
    fl(7'h00);
    wr(8'h00, 32'h0000000B, 2'h0);
    motor_speed <= 16'h0065;
    pwr();
    fl(7'h04);
    wr(8'h00, 32'h0000000F, 2'h0);
    fl(7'h00);
    wr(8'h00, 32'h0000000B, 2'h0);
    motor_speed <= 16'h0064;
    pwr();
    fl(7'h00);
    chk("host_rises", 32'h4, {24'h0, n_rise});
    stop_test();
  end
endmodule // swm_monitor_tb
`default_nettype wire
